// [src/pra_pkg.sv]
// constants for the paged host register and buffer space
// Function
// - registers and buffers form four pages; only the selected page is decoded
// - host writes page number; accesses go to that page until rewritten
// - page select register decodes at 0x7F on every page
// - page values 00 control, 01 receiver, 02 transmitter, 03 test
// - page 0 holds configuration and status; enabled status bits drive interrupt
// - page 1 shows receiver channel-status and user bits of last block
// - page 2 buffers are host written and feed the transmitted stream
// - page 2 buffers read back their stored contents
// - page 3 stays closed until the private unlock code is given
// - page 0 addresses 0x00 and 0x2D to 0x7E are reserved
package pra_pkg;
    // -------------------------------------------------------------
    // address map
    // -------------------------------------------------------------
    localparam logic [6:0] PAGE_ADDR     = 7'h7F;
    localparam logic [6:0] P0_FIRST      = 7'h01;
    localparam logic [6:0] P0_LAST       = 7'h2C;
    localparam logic [6:0] P0_STAT_ADDR  = 7'h02;
    localparam logic [6:0] P0_MASK_ADDR  = 7'h0B;
    localparam logic [6:0] P3_KEY_ADDR   = 7'h00;
    localparam logic [6:0] P3_TEST_ADDR  = 7'h01;
    localparam int         P0_COUNT      = 44;
    // -------------------------------------------------------------
    // page codes
    // -------------------------------------------------------------
    localparam logic [1:0] PG_CTRL       = 2'h0;
    localparam logic [1:0] PG_RX         = 2'h1;
    localparam logic [1:0] PG_TX         = 2'h2;
    localparam logic [1:0] PG_TEST       = 2'h3;
    // -------------------------------------------------------------
    // buffers, reset values, unlock
    // -------------------------------------------------------------
    localparam int         BUF_AW        = 6;
    localparam logic [7:0] BYTE_RST      = 8'h00;
    localparam logic [1:0] PAGE_RST      = 2'h0;
    // unlock key value is arbitrary
    localparam logic [7:0] UNLOCK_KEY    = 8'hA5;
endpackage

// [src/pra_buf_ram.sv]
// byte buffer with one write port and two asynchronous read ports
`timescale 1ns/1ps
module pra_buf_ram #(
    parameter int AW = 6
) (
    input  wire logic          clk_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [7:0]    wr_data_in,
    input  wire logic [AW-1:0] rd_addr_a_in,
    output logic [7:0]         rd_data_a_out,
    input  wire logic [AW-1:0] rd_addr_b_in,
    output logic [7:0]         rd_data_b_out
);
    // storage has no reset: contents are defined only once written
    logic [7:0] mem [0:(1<<AW)-1];

    // single write port
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // readers register the data themselves
    assign rd_data_a_out = mem[rd_addr_a_in];
    assign rd_data_b_out = mem[rd_addr_b_in];
endmodule

// [src/pra_top.sv]
// paged register and buffer space behind the serial host port
`timescale 1ns/1ps
module pra_top (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // host access from the serial control front end
    input  wire logic        reg_wr_en_in,
    input  wire logic        reg_rd_en_in,
    input  wire logic [6:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic [7:0]       reg_rdata_out,
    output logic             reg_rvalid_out,
    output logic [1:0]       page_out,
    // page 0 status events and interrupt
    input  wire logic [7:0]  evt_in,
    output logic             irq_out,
    // configuration read port for the function blocks
    input  wire logic [6:0]  blk_cfg_addr_in,
    output logic [7:0]       blk_cfg_data_out,
    // receiver capture side
    input  wire logic        rx_wr_en_in,
    input  wire logic [5:0]  rx_wr_addr_in,
    input  wire logic [7:0]  rx_wr_data_in,
    input  wire logic        rx_block_done_in,
    // audio_transmitter fetch side
    input  wire logic [5:0]  tx_rd_addr_in,
    output logic [7:0]       tx_rd_data_out,
    // factory test
    output logic             test_unlocked_out,
    output logic [7:0]       test_mode_out
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic [1:0] page_q;
    logic [7:0] cfg_q [0:pra_pkg::P0_COUNT-1];
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    logic [7:0] mask_q;
    logic       cap_bank_q;
    logic       unlock_q;
    logic [7:0] test_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    logic [7:0] txd_q;
    logic [7:0] cfgd_q;

    // page 0 ordinary register window, shared by host and block reads
    function automatic logic p0_hit(input logic [6:0] a);
        p0_hit = (a >= pra_pkg::P0_FIRST) && (a <= pra_pkg::P0_LAST);
    endfunction

    function automatic logic [5:0] p0_idx(input logic [6:0] a);
        logic [6:0] d;
        d = a - pra_pkg::P0_FIRST;
        p0_idx = d[5:0];
    endfunction

    // -------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------
    wire       is_page_a = (reg_addr_in == pra_pkg::PAGE_ADDR);
    wire       on_ctrl   = (page_q == pra_pkg::PG_CTRL) && !is_page_a;
    wire       on_rx     = (page_q == pra_pkg::PG_RX) && !is_page_a;
    wire       on_tx     = (page_q == pra_pkg::PG_TX) && !is_page_a;
    wire       on_test   = (page_q == pra_pkg::PG_TEST) && !is_page_a;
    wire       buf_hit   = !reg_addr_in[6];
    // reserved page 0 addresses fall outside p0_hit
    wire       p0_ok     = on_ctrl && p0_hit(reg_addr_in);
    wire       is_stat   = reg_addr_in == pra_pkg::P0_STAT_ADDR;
    wire       is_mask   = reg_addr_in == pra_pkg::P0_MASK_ADDR;
    wire [5:0] p0_wi     = p0_idx(reg_addr_in);
    wire       wr_page   = reg_wr_en_in && is_page_a;
    wire       wr_cfg    = reg_wr_en_in && p0_ok && !is_stat && !is_mask;
    wire       wr_mask   = reg_wr_en_in && p0_ok && is_mask;
    wire       wr_stat   = reg_wr_en_in && p0_ok && is_stat;
    wire       wr_tx     = reg_wr_en_in && on_tx && buf_hit;
    wire       wr_key    = reg_wr_en_in && on_test && (reg_addr_in == pra_pkg::P3_KEY_ADDR);
    wire       wr_test   = reg_wr_en_in && on_test && unlock_q
                           && (reg_addr_in == pra_pkg::P3_TEST_ADDR);

    // -------------------------------------------------------------
    // buffers
    // -------------------------------------------------------------
    logic [7:0] rx_host_d;
    logic [7:0] tx_host_d;
    logic [7:0] tx_fetch_d;
    logic [7:0] rx_unused_d;

    // receiver fills one bank while the host reads the finished one,
    // so a read never shows a half-captured block
    pra_buf_ram #(.AW(pra_pkg::BUF_AW + 1)) u_rx_buf (
        .clk_in        (clk_in),
        .wr_en_in      (rx_wr_en_in),
        .wr_addr_in    ({cap_bank_q, rx_wr_addr_in}),
        .wr_data_in    (rx_wr_data_in),
        .rd_addr_a_in  ({~cap_bank_q, reg_addr_in[5:0]}),
        .rd_data_a_out (rx_host_d),
        .rd_addr_b_in  ({cap_bank_q, rx_wr_addr_in}),
        .rd_data_b_out (rx_unused_d)
    );

    // host writes, host reads back, transmitter fetches
    pra_buf_ram #(.AW(pra_pkg::BUF_AW)) u_tx_buf (
        .clk_in        (clk_in),
        .wr_en_in      (wr_tx),
        .wr_addr_in    (reg_addr_in[5:0]),
        .wr_data_in    (reg_wdata_in),
        .rd_addr_a_in  (reg_addr_in[5:0]),
        .rd_data_a_out (tx_host_d),
        .rd_addr_b_in  (tx_rd_addr_in),
        .rd_data_b_out (tx_fetch_d)
    );

    // -------------------------------------------------------------
    // read data select
    // -------------------------------------------------------------
    wire [7:0] p0_rd   = !p0_ok  ? 8'h00 :
                         is_stat ? stat_q :
                         is_mask ? mask_q : cfg_q[p0_wi];
    wire [7:0] p3_rd   = !unlock_q ? 8'h00 :
                         (reg_addr_in == pra_pkg::P3_TEST_ADDR) ? test_q : 8'h00;
    wire [7:0] rd_mux  = is_page_a ? {6'h00, page_q} :
                         on_ctrl   ? p0_rd :
                         on_rx     ? (buf_hit ? rx_host_d : 8'h00) :
                         on_tx     ? (buf_hit ? tx_host_d : 8'h00) :
                         p3_rd;
    wire       cfg_ok  = p0_hit(blk_cfg_addr_in);
    wire [5:0] cfg_ri  = p0_idx(blk_cfg_addr_in);

    // sticky status: a new event wins over a clear in the same cycle
    assign stat_d = (stat_q & ~(wr_stat ? reg_wdata_in : 8'h00)) | evt_in;

    // -------------------------------------------------------------
    // page select and test unlock
    // -------------------------------------------------------------
    // page holds until the host rewrites it
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            page_q <= pra_pkg::PAGE_RST;
        end else if (wr_page) begin
            page_q <= reg_wdata_in[1:0];
        end
    end

    // unlock drops whenever the host leaves page 3, so test modes cannot linger
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            unlock_q <= 1'b0;
            test_q   <= pra_pkg::BYTE_RST;
        end else if (page_q != pra_pkg::PG_TEST) begin
            unlock_q <= 1'b0;
            test_q   <= pra_pkg::BYTE_RST;
        end else begin
            if (wr_key) begin
                unlock_q <= (reg_wdata_in == pra_pkg::UNLOCK_KEY);
            end
            if (wr_test) begin
                test_q <= reg_wdata_in;
            end
        end
    end

    // -------------------------------------------------------------
    // page 0 registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < pra_pkg::P0_COUNT; i++) begin
                cfg_q[i] <= pra_pkg::BYTE_RST;
            end
        end else if (wr_cfg) begin
            cfg_q[p0_wi] <= reg_wdata_in;
        end
    end

    // status and interrupt mask
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            stat_q <= pra_pkg::BYTE_RST;
            mask_q <= pra_pkg::BYTE_RST;
        end else begin
            stat_q <= stat_d;
            if (wr_mask) begin
                mask_q <= reg_wdata_in;
            end
        end
    end

    // -------------------------------------------------------------
    // receiver bank swap and registered outputs
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cap_bank_q <= 1'b0;
        end else if (rx_block_done_in) begin
            cap_bank_q <= ~cap_bank_q;
        end
    end

    // one cycle read latency for host and function blocks alike
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_q  <= pra_pkg::BYTE_RST;
            rvalid_q <= 1'b0;
            txd_q    <= pra_pkg::BYTE_RST;
            cfgd_q   <= pra_pkg::BYTE_RST;
        end else begin
            rvalid_q <= reg_rd_en_in;
            if (reg_rd_en_in) begin
                rdata_q <= rd_mux;
            end
            txd_q  <= tx_fetch_d;
            cfgd_q <= cfg_ok ? cfg_q[cfg_ri] : 8'h00;
        end
    end

    assign reg_rdata_out     = rdata_q;
    assign reg_rvalid_out    = rvalid_q;
    assign page_out          = page_q;
    assign irq_out           = |(stat_q & mask_q);
    assign blk_cfg_data_out  = cfgd_q;
    assign tx_rd_data_out    = txd_q;
    assign test_unlocked_out = unlock_q;
    assign test_mode_out     = test_q;
endmodule

// [dv/pra_top_chk.sv]
// concurrent checks on the host port of the paged register space
`timescale 1ns/1ps
module pra_top_chk (
    input wire logic       clk_in,
    input wire logic       sys_rst_in,
    input wire logic       reg_wr_en_in,
    input wire logic       reg_rd_en_in,
    input wire logic [6:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       reg_rvalid_out,
    input wire logic [1:0] page_out,
    input wire logic       test_unlocked_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // ------------------------------------------------
    // decoded request kinds
    // ------------------------------------------------
    logic       page_wr;
    logic       page_rd;
    logic       rsv_rd;
    logic       key_wr;
    logic [1:0] wpage;
    assign page_wr = reg_wr_en_in && reg_addr_in == pra_pkg::PAGE_ADDR;
    assign page_rd = reg_rd_en_in && reg_addr_in == pra_pkg::PAGE_ADDR;
    assign wpage   = reg_wdata_in[1:0];
    // reserved page 0 reads, page select itself excluded
    assign rsv_rd  = reg_rd_en_in && page_out == pra_pkg::PG_CTRL && !page_rd
                     && (reg_addr_in == 7'h00 || reg_addr_in > pra_pkg::P0_LAST);
    assign key_wr  = reg_wr_en_in && page_out == pra_pkg::PG_TEST
                     && reg_addr_in == pra_pkg::P3_KEY_ADDR
                     && reg_wdata_in == pra_pkg::UNLOCK_KEY;
    sequence s_page_wr;
        page_wr;
    endsequence
    // two cycles away from the test page give the unlock time to drop
    sequence s_off_test;
        (page_out != pra_pkg::PG_TEST) [*2];
    endsequence
    AST_RVALID_ONE: assert property (reg_rd_en_in |=> reg_rvalid_out)
        else $error("read got no valid");
    AST_NO_EXTRA_RVALID: assert property (!reg_rd_en_in |=> !reg_rvalid_out)
        else $error("valid without read");
    AST_PAGE_WRITE: assert property (s_page_wr |=> page_out == $past(wpage))
        else $error("page select write lost");
    AST_PAGE_HOLD: assert property (!page_wr |=> $stable(page_out))
        else $error("page moved without write");
    AST_PAGE_READ: assert property (page_rd |=> reg_rdata_out == {6'h00, $past(page_out)})
        else $error("page select read wrong");
    AST_RESERVED: assert property (rsv_rd |=> reg_rdata_out == 8'h00)
        else $error("reserved read not zero");
    AST_LOCKED_OFF: assert property (s_off_test |-> !test_unlocked_out)
        else $error("unlocked off the test page");
    AST_UNLOCK_KEY: assert property ($rose(test_unlocked_out) |-> $past(key_wr))
        else $error("unlock without key");
endmodule
bind pra_top pra_top_chk u_chk (
    .clk_in            (clk_in),
    .sys_rst_in        (sys_rst_in),
    .reg_wr_en_in      (reg_wr_en_in),
    .reg_rd_en_in      (reg_rd_en_in),
    .reg_addr_in       (reg_addr_in),
    .reg_wdata_in      (reg_wdata_in),
    .reg_rdata_out     (reg_rdata_out),
    .reg_rvalid_out    (reg_rvalid_out),
    .page_out          (page_out),
    .test_unlocked_out (test_unlocked_out)
);

// [dv/pra_rx_src.sv]
// receiver model: captures one 64 byte block, then publishes it
`timescale 1ns/1ps
module pra_rx_src (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       go_in,
    input  wire logic [7:0] base_in,
    output logic            wr_en_out,
    output logic [5:0]      addr_out,
    output logic [7:0]      data_out,
    output logic            done_out
);
    logic [6:0] cnt_q;
    logic       busy_q;
    // byte n of a block is base xor n; idle data is inverted so stale bytes never match
    assign wr_en_out = busy_q;
    assign addr_out  = cnt_q[5:0];
    assign data_out  = busy_q ? (base_in ^ {2'b00, cnt_q[5:0]}) : ~base_in;
    // done pulses once the last byte of the block is in
    always_ff @(posedge clk_in) begin
        done_out <= 1'b0;
        if (rst_in) begin
            busy_q <= 1'b0;
            cnt_q  <= 7'h00;
        end else if (go_in) begin
            busy_q <= 1'b1;
            cnt_q  <= 7'h00;
        end else if (busy_q) begin
            cnt_q <= cnt_q + 7'h01;
            if (cnt_q == 7'h3F) begin
                busy_q   <= 1'b0;
                done_out <= 1'b1;
            end
        end
    end
endmodule

// [dv/pra_top_tb_top.sv]
// self-checking bench for the paged register space
`timescale 1ns/1ps
module pra_top_tb_top;
    logic       clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic       go = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] base = 8'h00;
    logic [5:0] tx_addr = 6'h00;
    logic [7:0] evt = 8'h00;
    logic [6:0] cfg_addr = 7'h2C;
    logic [7:0] rdata, cfg, rx_data, tx_data, tmode;
    logic [5:0] rx_addr;
    logic [1:0] page;
    logic       rvalid, unl, rx_en, rx_done, irq;
    logic [6:0] rsv [3] = '{7'h00, 7'h2D, 7'h7E};
    int         err_total = 0;
    int         compares = 0;
    always #2 clk_in = ~clk_in;
    pra_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_wr_en_in(wr_en),
        .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .page_out(page),
        .evt_in(evt), .irq_out(irq), .blk_cfg_addr_in(cfg_addr), .blk_cfg_data_out(cfg),
        .rx_wr_en_in(rx_en), .rx_wr_addr_in(rx_addr), .rx_wr_data_in(rx_data),
        .rx_block_done_in(rx_done), .tx_rd_addr_in(tx_addr), .tx_rd_data_out(tx_data),
        .test_unlocked_out(unl), .test_mode_out(tmode));
    pra_rx_src u_rx (.clk_in(clk_in), .rst_in(sys_rst_in), .go_in(go), .base_in(base),
        .wr_en_out(rx_en), .addr_out(rx_addr), .data_out(rx_data), .done_out(rx_done));
    // ------------------------------------------------
    // host access tasks
    // ------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // strobe is one cycle wide; the #1 lets the taking edge settle
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_in);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk_in);
        rd_en <= 1'b0;
        #1;
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, exp);
    endtask
    // one cycle of status events, optionally with a write-1-to-clear in the same cycle
    task automatic stat_op(input logic [7:0] clr, input logic [7:0] e);
        @(posedge clk_in);
        wr_en <= |clr;
        addr  <= pra_pkg::P0_STAT_ADDR;
        wdata <= clr;
        evt   <= e;
        @(posedge clk_in);
        wr_en <= 1'b0;
        evt   <= 8'h00;
        #1;
    endtask
    task automatic results();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(7'h7F, 8'h00);
        // upper bits set on purpose: only the two low bits may stick
        for (int p = 3; p >= 0; p--) begin
            wr(7'h7F, 8'hFC | 8'(p));
            chk({6'h00, page}, 8'(p));
            rd(7'h7F, 8'(p));
        end
        wr(7'h2C, 8'h3C);
        rd(7'h2C, 8'h3C);
        chk(cfg, 8'h3C);
        // status bit 1 is masked off, bit 0 reaches the interrupt
        wr(pra_pkg::P0_MASK_ADDR, 8'h01);
        chk({7'h00, irq}, 8'h00);
        stat_op(8'h00, 8'h02);
        chk({7'h00, irq}, 8'h00);
        stat_op(8'h00, 8'h01);
        chk({7'h00, irq}, 8'h01);
        rd(pra_pkg::P0_STAT_ADDR, 8'h03);
        // a new event beats a clear of the same bit
        stat_op(8'h03, 8'h01);
        rd(pra_pkg::P0_STAT_ADDR, 8'h01);
        chk({7'h00, irq}, 8'h01);
        stat_op(8'h01, 8'h00);
        chk({7'h00, irq}, 8'h00);
        rd(pra_pkg::P0_STAT_ADDR, 8'h00);
        foreach (rsv[i]) begin
            wr(rsv[i], 8'hFF);
            rd(rsv[i], 8'h00);
        end
        // function blocks see zero for a reserved address as well
        @(posedge clk_in);
        cfg_addr <= 7'h2D;
        repeat (2) @(posedge clk_in);
        #1;
        chk(cfg, 8'h00);
        wr(7'h7F, 8'h02);
        for (int a = 0; a < 64; a += 63) begin
            wr(7'(a), 8'h50 + 8'(a));
            rd(7'(a), 8'h50 + 8'(a));
        end
        rd(7'h40, 8'h00);
        @(posedge clk_in);
        tx_addr <= 6'h3F;
        repeat (2) @(posedge clk_in);
        #1;
        chk(tx_data, 8'h8F);
        wr(7'h7F, 8'h01);
        // the most recent block must replace the one before it
        for (int b = 0; b < 2; b++) begin
            @(posedge clk_in);
            base <= b ? 8'hC3 : 8'h3C;
            go   <= 1'b1;
            @(posedge clk_in);
            go <= 1'b0;
            for (int i = 0; i < 100 && rx_done !== 1'b1; i++) @(posedge clk_in);
            chk({7'h00, rx_done}, 8'h01);
            rd(7'h00, base);
            rd(7'h3F, base ^ 8'h3F);
        end
        wr(7'h00, 8'hEE);
        rd(7'h00, 8'hC3);
        wr(7'h7F, 8'h03);
        wr(7'h01, 8'h5A);
        rd(7'h01, 8'h00);
        wr(pra_pkg::P3_KEY_ADDR, pra_pkg::UNLOCK_KEY);
        chk({7'h00, unl}, 8'h01);
        wr(7'h01, 8'h5A);
        chk(tmode, 8'h5A);
        wr(7'h7F, 8'h00);
        repeat (2) @(posedge clk_in);
        #1;
        chk({7'h00, unl}, 8'h00);
        chk(tmode, 8'h00);
        results();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end
endmodule
